// file: design/pnpcr_pkg.sv
`default_nettype none
// Register map, reset values and field masks of the configuration bank
package pnpcr_pkg;

  // Device slots inside the bank
  localparam int         NDEV     = 3;
  localparam logic [1:0] DEV_FDC  = 2'h0;
  localparam logic [1:0] DEV_PP   = 2'h1;
  localparam logic [1:0] DEV_SER2 = 2'h2;
  localparam logic [1:0] DEV_NONE = 2'h3;

  // Logical device numbers selected by the host
  localparam logic [2:0] LDN_FDC  = 3'h3;
  localparam logic [2:0] LDN_PP   = 3'h4;
  localparam logic [2:0] LDN_SER2 = 3'h5;

  // Register indexes within a logical device
  localparam logic [7:0] IDX_ACT     = 8'h30;
  localparam logic [7:0] IDX_RANGE   = 8'h31;
  localparam logic [7:0] IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYP = 8'h71;
  localparam logic [7:0] IDX_DMA0    = 8'h74;
  localparam logic [7:0] IDX_DMA1    = 8'h75;
  localparam logic [7:0] IDX_CFG     = 8'hf0;
  localparam logic [7:0] IDX_DRV_ID  = 8'hf1;

  // Values after hard and soft reset, slot order {SER2, PP, FDC}
  localparam logic [7:0]           RST_ZERO    = 8'h00;
  localparam logic [NDEV-1:0][7:0] RST_BASE_HI = {8'h02, 8'h02, 8'h03};
  localparam logic [NDEV-1:0][7:0] RST_BASE_LO = {8'hf8, 8'h78, 8'hf2};
  localparam logic [NDEV-1:0][7:0] RST_IRQ_SEL = {8'h03, 8'h07, 8'h06};
  localparam logic [NDEV-1:0][7:0] RST_IRQ_TYP = {8'h03, 8'h00, 8'h03};
  localparam logic [NDEV-1:0][7:0] RST_DMA0    = {8'h04, 8'h04, 8'h02};
  localparam logic [NDEV-1:0][7:0] RST_DMA1    = {8'h04, 8'h04, 8'h04};

  // Hard reset only values of the device configuration registers
  localparam logic [7:0] RST_FDC_CFG  = 8'h00;
  localparam logic [7:0] RST_FDC_DRV  = 8'h00;
  localparam logic [7:0] RST_PP_CFG   = 8'h00;
  localparam logic [7:0] RST_SER2_CFG = 8'h00;

  // Writable bit masks; cleared bits read zero or keep their value
  localparam logic [NDEV-1:0][7:0] WMASK_BASE_HI = {8'hff, 8'h03, 8'hff};
  localparam logic [NDEV-1:0][7:0] WMASK_BASE_LO = {8'hf8, 8'hfc, 8'hfa};
  localparam logic [7:0]           WMASK_IRQ_TYP = 8'h02;
  localparam logic [NDEV-1:0][7:0] WMASK_DMA1    = {8'hff, 8'h00, 8'h00};

  // Host I/O decode: address bits compared against the base
  localparam logic [NDEV-1:0][15:0] IO_DECODE_MASK = {16'hfff8, 16'hfffc, 16'hfff8};

  // Channel code that means no DMA channel assigned
  localparam logic [7:0] DMA_NONE = 8'h04;

  // Cycles after reset release before the strap is trusted
  localparam int STRAP_SETTLE_CYC = 3;

endpackage
`default_nettype wire

// file: design/pnpcr_regs.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pnpcr_regs #(
  parameter int STRAP_SETTLE = pnpcr_pkg::STRAP_SETTLE_CYC
) (
  // Clock and resets
  input  wire logic                                    clk,
  input  wire logic                                    rst_n,
  input  wire logic                                    softRst,
  // Register port
  input  wire logic [2:0]                              regLdn,
  input  wire logic [7:0]                              regAddr,
  input  wire logic [7:0]                              regWrData,
  input  wire logic                                    regWr,
  input  wire logic                                    regRd,
  output var  logic [7:0]                              regRdData,
  // Straps and neighbouring logic
  input  wire logic                                    activationStrap,
  input  wire logic [pnpcr_pkg::NDEV-1:0]              functionEnable,
  input  wire logic                                    ppExtendedMode,
  // Host I/O decode
  input  wire logic [15:0]                             ioAddr,
  input  wire logic                                    ioCycle,
  output var  logic [pnpcr_pkg::NDEV-1:0]              ioHit,
  // Interrupt and DMA routing
  input  wire logic [pnpcr_pkg::NDEV-1:0]              devIrq,
  output var  logic [pnpcr_pkg::NDEV-1:0]              irqOut,
  input  wire logic [pnpcr_pkg::NDEV-1:0]              devDmaReq,
  input  wire logic                                    serial2TxDmaReq,
  output var  logic [pnpcr_pkg::NDEV-1:0]              dmaReqOut,
  output var  logic                                    serial2TxDmaReqOut,
  // Configuration towards the functions
  output var  logic [pnpcr_pkg::NDEV-1:0]              devActive,
  output var  logic [pnpcr_pkg::NDEV-1:0][7:0]         baseHigh,
  output var  logic [pnpcr_pkg::NDEV-1:0][7:0]         baseLow,
  output var  logic [pnpcr_pkg::NDEV-1:0][7:0]         irqSelect,
  output var  logic [pnpcr_pkg::NDEV-1:0][7:0]         irqType,
  output var  logic [pnpcr_pkg::NDEV-1:0][7:0]         dmaSelect,
  output var  logic [7:0]                              fdcConfig,
  output var  logic [7:0]                              fdcDriveIdent,
  output var  logic [7:0]                              ppConfig,
  output var  logic [7:0]                              serial2Config
);

  localparam int NDEV = pnpcr_pkg::NDEV;

  // Settle count must fit the 3-bit counter
  if (STRAP_SETTLE < 1 || STRAP_SETTLE > 7) begin : g_badSettle
    $error("STRAP_SETTLE must lie between 1 and 7");
  end

  // Logical device number to slot; used by both read and write paths
  function automatic logic [1:0] ldnToDev(input logic [2:0] ldn);
    case (ldn)
      pnpcr_pkg::LDN_FDC:  return pnpcr_pkg::DEV_FDC;
      pnpcr_pkg::LDN_PP:   return pnpcr_pkg::DEV_PP;
      pnpcr_pkg::LDN_SER2: return pnpcr_pkg::DEV_SER2;
      default:             return pnpcr_pkg::DEV_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [NDEV-1:0][7:0] act_q;
  logic [NDEV-1:0][7:0] range_q;
  logic [NDEV-1:0][7:0] baseHi_q;
  logic [NDEV-1:0][7:0] baseLo_q;
  logic [NDEV-1:0][7:0] irqSel_q;
  logic [NDEV-1:0][7:0] irqTyp_q;
  logic [NDEV-1:0][7:0] dma0_q;
  logic [NDEV-1:0][7:0] dma1_q;
  logic [7:0]           fdcCfg_q;
  logic [7:0]           fdcDrv_q;
  logic [7:0]           ppCfg_q;
  logic [7:0]           ser2Cfg_q;
  logic                 ppLevel_q;
  logic [7:0]           rdData_q;
  logic [NDEV-1:0]      active_q;
  logic [NDEV-1:0]      ioHit_q;
  logic [NDEV-1:0]      irqOut_q;
  logic [NDEV-1:0]      dmaOut_q;
  logic                 txDmaOut_q;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release
  logic       strapS1_q;
  logic       strapS2_q;
  logic       strapS3_q;
  logic [2:0] settleCnt_q;
  logic       strapDone_q;
  logic       strapVal_q;
  wire        settled   = (settleCnt_q == 3'(STRAP_SETTLE));
  wire        strapLoad = !strapDone_q && settled && (strapS2_q == strapS3_q);

  // Three-stage synchroniser; stage one feeds stage two only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strapS1_q <= 1'b0;
      strapS2_q <= 1'b0;
      strapS3_q <= 1'b0;
    end else begin
      strapS1_q <= activationStrap;
      strapS2_q <= strapS1_q;
      strapS3_q <= strapS2_q;
    end
  end

  // Waiting lets reset-time zeros leave the chain before the value counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settleCnt_q <= 3'h0;
      strapDone_q <= 1'b0;
      strapVal_q  <= 1'b0;
    end else begin
      if (!settled) settleCnt_q <= settleCnt_q + 3'h1;
      if (strapLoad) begin
        strapDone_q <= 1'b1;
        strapVal_q  <= strapS3_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  wire [1:0]       accDev = ldnToDev(regLdn);
  wire [NDEV-1:0]  wrDev;
  wire [NDEV-1:0][7:0] devRd;
  wire [NDEV-1:0][7:0] cfgRd = {ser2Cfg_q, ppCfg_q, fdcCfg_q};
  wire [NDEV-1:0][7:0] drvRd = {8'h00, 8'h00, fdcDrv_q};

  // Per-device register sets; resets honour masks, fixed base bits stay zero and IRQ type bit 0 stays set on floppy and serial, reads ppLevel_q on parallel
  for (genvar d = 0; d < NDEV; d++) begin : g_dev
    assign wrDev[d] = regWr && (accDev == 2'(d));
    wire [7:0] typRd = (d == pnpcr_pkg::DEV_PP) ? {irqTyp_q[d][7:1], ppLevel_q} : irqTyp_q[d];
    wire [7:0] actRst = (d == pnpcr_pkg::DEV_FDC) ? {7'h00, strapVal_q} : pnpcr_pkg::RST_ZERO;

    // Read selection
    assign devRd[d] = (regAddr == pnpcr_pkg::IDX_ACT)     ? act_q[d]    :
                      (regAddr == pnpcr_pkg::IDX_RANGE)   ? range_q[d]  :
                      (regAddr == pnpcr_pkg::IDX_BASE_HI) ? baseHi_q[d] :
                      (regAddr == pnpcr_pkg::IDX_BASE_LO) ? baseLo_q[d] :
                      (regAddr == pnpcr_pkg::IDX_IRQ_SEL) ? irqSel_q[d] :
                      (regAddr == pnpcr_pkg::IDX_IRQ_TYP) ? typRd       :
                      (regAddr == pnpcr_pkg::IDX_DMA0)    ? dma0_q[d]   :
                      (regAddr == pnpcr_pkg::IDX_DMA1)    ? dma1_q[d]   :
                      (regAddr == pnpcr_pkg::IDX_CFG)     ? cfgRd[d]    :
                      (regAddr == pnpcr_pkg::IDX_DRV_ID)  ? drvRd[d]    : 8'h00;

    // Same defaults on hard and soft reset except floppy activation, which soft reset takes from the strap; writes beat strap load
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        act_q[d]    <= pnpcr_pkg::RST_ZERO;
        range_q[d]  <= pnpcr_pkg::RST_ZERO;
        baseHi_q[d] <= pnpcr_pkg::RST_BASE_HI[d];
        baseLo_q[d] <= pnpcr_pkg::RST_BASE_LO[d];
        irqSel_q[d] <= pnpcr_pkg::RST_IRQ_SEL[d];
        irqTyp_q[d] <= pnpcr_pkg::RST_IRQ_TYP[d];
        dma0_q[d]   <= pnpcr_pkg::RST_DMA0[d];
        dma1_q[d]   <= pnpcr_pkg::RST_DMA1[d];
      end else if (softRst) begin
        act_q[d]    <= actRst;
        range_q[d]  <= pnpcr_pkg::RST_ZERO;
        baseHi_q[d] <= pnpcr_pkg::RST_BASE_HI[d];
        baseLo_q[d] <= pnpcr_pkg::RST_BASE_LO[d];
        irqSel_q[d] <= pnpcr_pkg::RST_IRQ_SEL[d];
        irqTyp_q[d] <= pnpcr_pkg::RST_IRQ_TYP[d];
        dma0_q[d]   <= pnpcr_pkg::RST_DMA0[d];
        dma1_q[d]   <= pnpcr_pkg::RST_DMA1[d];
      end else if (wrDev[d]) begin
        case (regAddr)
          pnpcr_pkg::IDX_ACT:     act_q[d]    <= regWrData;
          pnpcr_pkg::IDX_RANGE:   range_q[d]  <= regWrData;
          pnpcr_pkg::IDX_BASE_HI: baseHi_q[d] <= regWrData & pnpcr_pkg::WMASK_BASE_HI[d];
          pnpcr_pkg::IDX_BASE_LO: baseLo_q[d] <= regWrData & pnpcr_pkg::WMASK_BASE_LO[d];
          pnpcr_pkg::IDX_IRQ_SEL: irqSel_q[d] <= regWrData;
          pnpcr_pkg::IDX_IRQ_TYP: irqTyp_q[d] <= (irqTyp_q[d] & ~pnpcr_pkg::WMASK_IRQ_TYP)
                                                | (regWrData & pnpcr_pkg::WMASK_IRQ_TYP);
          pnpcr_pkg::IDX_DMA0:    dma0_q[d]   <= regWrData;
          pnpcr_pkg::IDX_DMA1:    dma1_q[d]   <= (dma1_q[d] & ~pnpcr_pkg::WMASK_DMA1[d])
                                                | (regWrData & pnpcr_pkg::WMASK_DMA1[d]);
          default:                act_q[d]    <= act_q[d];
        endcase
      end else if (strapLoad && d == pnpcr_pkg::DEV_FDC) begin
        act_q[d] <= {7'h00, strapS3_q};
      end
    end

    // Activation gating of decode, interrupt and DMA
    wire liveNow = act_q[d][0] && functionEnable[d];
    wire baseHit = ((ioAddr ^ {baseHi_q[d], baseLo_q[d]}) & pnpcr_pkg::IO_DECODE_MASK[d]) == 16'h0000;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        active_q[d] <= 1'b0;
        ioHit_q[d]  <= 1'b0;
        irqOut_q[d] <= 1'b0;
        dmaOut_q[d] <= 1'b0;
      end else begin
        active_q[d] <= liveNow;
        ioHit_q[d]  <= liveNow && ioCycle && baseHit;
        irqOut_q[d] <= liveNow && devIrq[d];
        dmaOut_q[d] <= liveNow && devDmaReq[d] && (dma0_q[d] != pnpcr_pkg::DMA_NONE);
      end
    end

    // Outputs straight from the register flops
    assign baseHigh[d]  = baseHi_q[d];
    assign baseLow[d]   = baseLo_q[d];
    assign irqSelect[d] = irqSel_q[d];
    assign irqType[d]   = typRd;
    assign dmaSelect[d] = dma0_q[d];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device configuration registers; soft reset leaves them alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fdcCfg_q  <= pnpcr_pkg::RST_FDC_CFG;
      fdcDrv_q  <= pnpcr_pkg::RST_FDC_DRV;
      ppCfg_q   <= pnpcr_pkg::RST_PP_CFG;
      ser2Cfg_q <= pnpcr_pkg::RST_SER2_CFG;
    end else begin
      if (wrDev[pnpcr_pkg::DEV_FDC] && regAddr == pnpcr_pkg::IDX_CFG) fdcCfg_q <= regWrData;
      if (wrDev[pnpcr_pkg::DEV_FDC] && regAddr == pnpcr_pkg::IDX_DRV_ID) fdcDrv_q <= regWrData;
      if (wrDev[pnpcr_pkg::DEV_PP] && regAddr == pnpcr_pkg::IDX_CFG) ppCfg_q <= regWrData;
      if (wrDev[pnpcr_pkg::DEV_SER2] && regAddr == pnpcr_pkg::IDX_CFG) ser2Cfg_q <= regWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, serial transmit DMA and mode tracking
  wire [7:0] rdData_d = (accDev == pnpcr_pkg::DEV_NONE) ? 8'h00 : devRd[accDev];
  wire       txLive   = act_q[pnpcr_pkg::DEV_SER2][0] && functionEnable[pnpcr_pkg::DEV_SER2];

  // Read data held between reads so the port never floats
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q   <= 8'h00;
      ppLevel_q  <= 1'b0;
      txDmaOut_q <= 1'b0;
    end else begin
      if (regRd) rdData_q <= rdData_d;
      ppLevel_q  <= ppExtendedMode;
      txDmaOut_q <= txLive && serial2TxDmaReq
                    && (dma1_q[pnpcr_pkg::DEV_SER2] != pnpcr_pkg::DMA_NONE);
    end
  end

  assign regRdData          = rdData_q;
  assign devActive          = active_q;
  assign ioHit              = ioHit_q;
  assign irqOut             = irqOut_q;
  assign dmaReqOut          = dmaOut_q;
  assign serial2TxDmaReqOut = txDmaOut_q;
  assign fdcConfig          = fdcCfg_q;
  assign fdcDriveIdent      = fdcDrv_q;
  assign ppConfig           = ppCfg_q;
  assign serial2Config      = ser2Cfg_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_softRst;
    softRst;
  endsequence
  sequence s_wrFdcLo;
    wrDev[pnpcr_pkg::DEV_FDC] && !softRst && regAddr == pnpcr_pkg::IDX_BASE_LO;
  endsequence

  property p_fdcActStrap;
    s_softRst |=> act_q[pnpcr_pkg::DEV_FDC] == {7'h00, $past(strapVal_q)};
  endproperty
  a_fdcActStrap: assert property (p_fdcActStrap) else $error("floppy activation not strap value");

  property p_fdcBaseRst;
    s_softRst |=> baseHigh[0] == 8'h03 && baseLow[0] == 8'hf2;
  endproperty
  a_fdcBaseRst: assert property (p_fdcBaseRst) else $error("floppy base reset wrong");

  property p_fdcLoMask;
    s_wrFdcLo |=> baseLow[0] == ($past(regWrData) & 8'hfa);
  endproperty
  a_fdcLoMask: assert property (p_fdcLoMask) else $error("floppy base low fixed bits written");

  property p_fdcIrqRst;
    s_softRst |=> irqSelect[0] == 8'h06 ##1 irqType[0][7:2] == 6'h00 && irqType[0][0];
  endproperty
  a_fdcIrqRst: assert property (p_fdcIrqRst) else $error("floppy irq reset wrong");

  property p_cfgKeep;
    softRst && !regWr |=> fdcConfig == $past(fdcConfig) && fdcDriveIdent == $past(fdcDriveIdent)
                          && ppConfig == $past(ppConfig) && serial2Config == $past(serial2Config);
  endproperty
  a_cfgKeep: assert property (p_cfgKeep) else $error("config register lost at soft reset");

  property p_ppHiZero;
    regWr |=> baseHigh[1][7:2] == 6'h00 ##1 baseLow[1][1:0] == 2'b00;
  endproperty
  a_ppHiZero: assert property (p_ppHiZero) else $error("parallel base fixed bits nonzero");

  property p_ppTypeBit;
    regRd && accDev == pnpcr_pkg::DEV_PP && regAddr == pnpcr_pkg::IDX_IRQ_TYP
      |=> regRdData[0] == $past(ppLevel_q) && regRdData[7:2] == 6'h00;
  endproperty
  a_ppTypeBit: assert property (p_ppTypeBit) else $error("parallel irq type read wrong");

  property p_ppRst;
    s_softRst |=> irqSelect[1] == 8'h07 && irqTyp_q[1] == 8'h00 && baseHigh[1] == 8'h02 && baseLow[1] == 8'h78;
  endproperty
  a_ppRst: assert property (p_ppRst) else $error("parallel reset values wrong");

  property p_serRst;
    s_softRst |=> baseHigh[2] == 8'h02 && baseLow[2] == 8'hf8 && irqSelect[2] == 8'h03
                  && irqType[2] == 8'h03 && dma0_q[2] == 8'h04 && dma1_q[2] == 8'h04;
  endproperty
  a_serRst: assert property (p_serRst) else $error("serial reset values wrong");

  property p_serDma1;
    wrDev[2] && !softRst && regAddr == pnpcr_pkg::IDX_DMA1 |=> dma1_q[2] == $past(regWrData);
  endproperty
  a_serDma1: assert property (p_serDma1) else $error("serial transmit DMA select not written");

  property p_funcGate;
    !functionEnable[0] |=> !devActive[0] && !irqOut[0] && !ioHit[0] && !dmaReqOut[0];
  endproperty
  a_funcGate: assert property (p_funcGate) else $error("floppy active without function enable");

  property p_noDma;
    dma0_q[1] == pnpcr_pkg::DMA_NONE |=> !dmaReqOut[1];
  endproperty
  a_noDma: assert property (p_noDma) else $error("DMA routed with no channel");

  property p_inactive;
    !act_q[2][0] |=> !ioHit[2] && !irqOut[2];
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive serial port responds");

  // Strap capture after hard reset; a same-cycle write or soft reset wins
  property p_fdcStrapLoad;
    strapLoad && !softRst && !wrDev[pnpcr_pkg::DEV_FDC]
      |=> act_q[pnpcr_pkg::DEV_FDC] == {7'h00, $past(strapS3_q)};
  endproperty
  a_fdcStrapLoad: assert property (p_fdcStrapLoad) else $error("floppy activation missed strap");

  property p_ppLoMask;
    wrDev[pnpcr_pkg::DEV_PP] && !softRst && regAddr == pnpcr_pkg::IDX_BASE_LO |=> baseLow[1][1:0] == 2'b00;
  endproperty
  a_ppLoMask: assert property (p_ppLoMask) else $error("parallel base low fixed bits written");

  property p_serLoMask;
    wrDev[pnpcr_pkg::DEV_SER2] && !softRst && regAddr == pnpcr_pkg::IDX_BASE_LO |=> baseLow[2][2:0] == 3'b000;
  endproperty
  a_serLoMask: assert property (p_serLoMask) else $error("serial base low fixed bits written");

  property p_serTypWr;
    wrDev[pnpcr_pkg::DEV_SER2] && !softRst && regAddr == pnpcr_pkg::IDX_IRQ_TYP
      |=> irqType[2] == {6'h00, $past(regWrData[1]), 1'b1};
  endproperty
  a_serTypWr: assert property (p_serTypWr) else $error("serial irq type fixed bits written");

  property p_txNoDma;
    dma1_q[pnpcr_pkg::DEV_SER2] == pnpcr_pkg::DMA_NONE |=> !serial2TxDmaReqOut;
  endproperty
  a_txNoDma: assert property (p_txNoDma) else $error("transmit DMA routed with no channel");

endmodule // pnpcr_regs
`default_nettype wire

// file: bench/pnpcr_host.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Host configuration side of the register port
module pnpcr_host (
  // Clock
  input  wire logic       clk,
  // Register port
  output var  logic [2:0] regLdn,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData,
  output var  logic       regWr,
  output var  logic       regRd,
  input  wire logic [7:0] regRdData
);
  // Idle bus at time zero
  initial begin
    regLdn = 3'h0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write cycle; called right after a rising edge, gap cycle so strobes never retoggle in one step
  task automatic wr(input logic [2:0] l, input logic [7:0] a, input logic [7:0] d);
    regLdn <= l;
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask

  // Read cycle; data taken in the cycle after the strobe
  task automatic rd(input logic [2:0] l, input logic [7:0] a, output logic [7:0] d);
    regLdn <= l;
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    d = regRdData;
  endtask
endmodule // pnpcr_host
`default_nettype wire

// file: bench/pnpcr_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module pnpcr_regs_test;
  // Stimulus and observed signals
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             softRst = 1'b0;
  logic             activationStrap = 1'b1;
  logic [2:0]       functionEnable = 3'b111;
  logic             ppExtendedMode = 1'b0;
  logic [15:0]      ioAddr = 16'h0000;
  logic             ioCycle = 1'b0;
  logic [2:0]       devIrq = 3'b000;
  logic [2:0]       devDmaReq = 3'b000;
  logic             serial2TxDmaReq = 1'b0;
  logic [2:0]       regLdn;
  logic [7:0]       regAddr;
  logic [7:0]       regWrData;
  logic             regWr;
  logic             regRd;
  logic [7:0]       regRdData;
  logic [2:0]       ioHit;
  logic [2:0]       irqOut;
  logic [2:0]       dmaReqOut;
  logic             serial2TxDmaReqOut;
  logic [2:0]       devActive;
  logic [2:0][7:0]  baseHigh, baseLow, irqSelect, irqType, dmaSelect;
  logic [7:0]       fdcConfig, fdcDriveIdent, ppConfig, serial2Config;
  logic [31:0]      seed = 32'h0000_000d;
  logic [2:0][9:0][7:0] shadow;
  int               mismatches = 0;
  int               checked = 0;
  logic [9:0][7:0]  idxList = {8'hf1, 8'hf0, 8'h75, 8'h74, 8'h71, 8'h70, 8'h61, 8'h60, 8'h31, 8'h30};

  // 20 MHz clock
  always #25 clk = ~clk;

  pnpcr_host host (.clk(clk), .regLdn(regLdn), .regAddr(regAddr), .regWrData(regWrData),
                   .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

  pnpcr_regs dut (.clk(clk), .rst_n(rst_n), .softRst(softRst), .regLdn(regLdn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .activationStrap(activationStrap), .functionEnable(functionEnable), .ppExtendedMode(ppExtendedMode),
    .ioAddr(ioAddr), .ioCycle(ioCycle), .ioHit(ioHit), .devIrq(devIrq), .irqOut(irqOut),
    .devDmaReq(devDmaReq), .serial2TxDmaReq(serial2TxDmaReq), .dmaReqOut(dmaReqOut),
    .serial2TxDmaReqOut(serial2TxDmaReqOut), .devActive(devActive), .baseHigh(baseHigh),
    .baseLow(baseLow), .irqSelect(irqSelect), .irqType(irqType), .dmaSelect(dmaSelect),
    .fdcConfig(fdcConfig), .fdcDriveIdent(fdcDriveIdent), .ppConfig(ppConfig),
    .serial2Config(serial2Config));

  ////////////////////////////////////////////////////////////////////////////////
  // Xorshift source, fixed start so runs repeat
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // Reset value per slot and index; configs are hard reset only
  function automatic logic [7:0] rstVal(input int s, input logic [7:0] a);
    case (a)
      8'h30: return (s == 0) ? {7'h00, activationStrap} : 8'h00;
      8'h60: return (s == 0) ? 8'h03 : 8'h02;
      8'h61: return (s == 0) ? 8'hf2 : (s == 1) ? 8'h78 : 8'hf8;
      8'h70: return (s == 0) ? 8'h06 : (s == 1) ? 8'h07 : 8'h03;
      8'h71: return (s == 1) ? {7'h00, ppExtendedMode} : 8'h03;
      8'h74: return (s == 0) ? 8'h02 : 8'h04;
      8'h75: return 8'h04;
      default: return 8'h00;
    endcase
  endfunction

  // Writable bits; F1h exists on the floppy slot only
  function automatic logic [7:0] wmask(input int s, input logic [7:0] a);
    case (a)
      8'h60: return (s == 1) ? 8'h03 : 8'hff;
      8'h61: return (s == 0) ? 8'hfa : (s == 1) ? 8'hfc : 8'hf8;
      8'h71: return 8'h02;
      8'h75: return (s == 2) ? 8'hff : 8'h00;
      8'hf1: return (s == 0) ? 8'hff : 8'h00;
      default: return 8'hff;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Routing outputs {ioHit, irqOut, dmaReqOut, transmit request}
  task automatic checkRoute(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: routing got %b expected %b", $time, got, exp);
    end
  endtask

  // Verdict, reached from the main sequence or the watchdog
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hard reset; wait out strap capture before trusting activation
  task automatic hardReset(input logic s);
    activationStrap <= s;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    for (int d = 0; d < 3; d++)
      for (int i = 0; i < 10; i++)
        shadow[d][i] = rstVal(d, idxList[i]);
  endtask

  // Soft reset leaves F0h/F1h alone
  task automatic softReset();
    softRst <= 1'b1;
    @(posedge clk);
    softRst <= 1'b0;
    @(posedge clk);
    for (int d = 0; d < 3; d++)
      for (int i = 0; i < 8; i++)
        shadow[d][i] = rstVal(d, idxList[i]);
  endtask

  // Random data into every register, plus an unmapped device
  task automatic writeAll();
    logic [7:0] v;
    host.wr(3'h0, 8'h30, rnd());
    for (int d = 0; d < 3; d++)
      for (int i = 0; i < 10; i++) begin
        v = rnd();
        host.wr(3'(d + 3), idxList[i], v);
        shadow[d][i] = (v & wmask(d, idxList[i])) | (shadow[d][i] & ~wmask(d, idxList[i]));
      end
  endtask

  // Read back every register; unmapped places read zero
  task automatic checkAll();
    logic [7:0] r;
    host.rd(3'h0, 8'h30, r);
    check({2'b00, r}, 10'h000);
    host.rd(3'h3, 8'h40, r);
    check({2'b00, r}, 10'h000);
    for (int d = 0; d < 3; d++)
      for (int i = 0; i < 10; i++) begin
        host.rd(3'(d + 3), idxList[i], r);
        check({2'b00, r}, {2'b00, shadow[d][i]});
      end
    // Configuration outputs mirror the same registers
    for (int d = 0; d < 3; d++) begin
      check({2'b00, baseHigh[d]}, {2'b00, shadow[d][2]});
      check({2'b00, baseLow[d]}, {2'b00, shadow[d][3]});
      check({2'b00, irqSelect[d]}, {2'b00, shadow[d][4]});
      check({2'b00, irqType[d]}, {2'b00, shadow[d][5]});
      check({2'b00, dmaSelect[d]}, {2'b00, shadow[d][6]});
      check({9'h000, devActive[d]}, {9'h000, shadow[d][0][0]});
    end
    check({2'b00, fdcConfig}, {2'b00, shadow[0][8]});
    check({2'b00, fdcDriveIdent}, {2'b00, shadow[0][9]});
    check({2'b00, ppConfig}, {2'b00, shadow[1][8]});
    check({2'b00, serial2Config}, {2'b00, shadow[2][8]});
  endtask

  // Routing outputs after the one-cycle pipeline has settled
  task automatic probe(input logic [9:0] e);
    repeat (3) @(posedge clk);
    checkRoute({ioHit, irqOut, dmaReqOut, serial2TxDmaReqOut}, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard, far above the roughly 600 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  // Main sequence: strap 1 with normal mode, then strap 0 with extended mode
  initial begin
    for (int k = 0; k < 2; k++) begin
      ppExtendedMode <= k[0];
      hardReset(~k[0]);
      checkAll();
      writeAll();
      checkAll();
      softReset();
      checkAll();
    end
    devIrq <= 3'b111;
    devDmaReq <= 3'b111;
    serial2TxDmaReq <= 1'b1;
    ioCycle <= 1'b1;
    ioAddr <= 16'h03f4;
    probe(10'h000);
    host.wr(3'h3, 8'h30, 8'h01);
    probe({3'b001, 3'b001, 3'b001, 1'b0});
    functionEnable <= 3'b110;
    probe(10'h000);
    functionEnable <= 3'b111;
    host.wr(3'h3, 8'h74, 8'h04);
    probe({3'b001, 3'b001, 3'b000, 1'b0});
    host.wr(3'h5, 8'h30, 8'h01);
    ioAddr <= 16'h02fa;
    probe({3'b100, 3'b101, 3'b000, 1'b0});
    host.wr(3'h5, 8'h74, 8'h01);
    host.wr(3'h5, 8'h75, 8'h03);
    probe({3'b100, 3'b101, 3'b100, 1'b1});
    // Parallel port: four-byte window, no DMA channel at reset
    host.wr(3'h4, 8'h30, 8'h01);
    ioAddr <= 16'h027b;
    probe({3'b010, 3'b111, 3'b100, 1'b1});
    wrap_up();
  end
endmodule // pnpcr_regs_test
`default_nettype wire
